/* logic/rxdsa_map.svh */
`ifndef RXDSA_MAP_SVH
`define RXDSA_MAP_SVH
`define RXDSA_OFF_CTRL  8'h00
`define RXDSA_OFF_RATE  8'h04
`define RXDSA_OFF_OOK   8'h08
`define RXDSA_OFF_CHAN  8'h0c
`define RXDSA_OFF_TMO   8'h10
`define RXDSA_OFF_FREQ  8'h14
`define RXDSA_OFF_FEI   8'h18
`define RXDSA_OFF_STAT  8'h1c
`define RXDSA_RST_CTRL  9'h040
`define RXDSA_RST_RATE  16'h1a0b
`define RXDSA_RST_OOK   24'h0c_4004
`define RXDSA_RST_CHAN  24'h00_8b55
`define RXDSA_RST_TMO   16'h0000
`define RXDSA_RST_FREQ  24'he4_c000
`define RXDSA_BIT_CORR  9
`define RXDSA_BIT_FEI   10
`define RXDSA_BIT_TEMP  11
`define RXDSA_BIT_TMO   3
`define RXDSA_MODE_STBY 3'h1
`define RXDSA_MODE_FS   3'h2
`define RXDSA_MODE_RX   3'h4
`define RXDSA_PEAK_DROP 8'h0c
`define RXDSA_OFS_SHIFT 3
`define RXDSA_FEI_LAST  3'h3
`define RXDSA_TMO_SHIFT 3
`define RXDSA_CLK_MHZ   10
`define RXDSA_TEMP_US   100
`define RXDSA_TEMP_CYC  (`RXDSA_TEMP_US * `RXDSA_CLK_MHZ - 2)
`define RXDSA_TEMP_ZERO 8'h80
`endif

/* logic/rxdsa_pkg.sv */
package rxdsa_pkg;
    typedef enum logic [1:0] {
        AFC_IDLE  = 2'b00,
        AFC_CLEAR = 2'b01,
        AFC_MEAS  = 2'b10,
        AFC_APPLY = 2'b11
    } rxdsa_afc_state_t;
    typedef enum logic [1:0] {
        THR_PEAK  = 2'b00,
        THR_FIXED = 2'b01,
        THR_AVG   = 2'b10
    } rxdsa_thr_t;
    typedef struct packed {
        logic [2:0] op_mode;
        logic       ook;
        logic       low_index;
        logic       auto_clear;
        logic       auto_en;
        logic       sync_off;
        logic       packet;
    } rxdsa_ctrl_t;
endpackage

/* logic/rxdsa_core.sv */
// Behaviour
// - fsk output can feed bit synchronizer
// - ook bit is rssi above selected threshold
// - peak threshold is peak minus 6 dB
// - peak decays per period, stops at floor
// - fixed uses floor, average uses mean
// - synchronizer drives clock pin, can disable
// - packet mode forces synchronizer on
// - bit period from rate divider bytes
// - measured error stored signed in result
// - measurement done within four bit periods
// - correction subtracted from carrier word
// - auto on rx entry, else launch bit
// - auto clear undoes previous correction first
// - wider bandwidth only during correction phase
// - low index adds offset times 488 Hz
// - temp only in standby/fs, under 100us
// - temp result minus one degree per lsb
// - timeout events on start and level hold
`timescale 1ns/1ps
`include "rxdsa_map.svh"
module rxdsa_core (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               fsk_bit,
    input  wire logic [7:0]         rssi_level,
    input  wire logic signed [15:0] freq_error_in,
    input  wire logic [7:0]         temp_adc,
    input  wire logic               signal_level_flag,
    output logic                    recovered_data,
    output logic                    recovered_clock_pin,
    output logic      [23:0]        carrier_word,
    output logic      [7:0]         channel_bw,
    output logic                    timeout_irq
);
    rxdsa_pkg::rxdsa_ctrl_t      ctrl_q;
    rxdsa_pkg::rxdsa_afc_state_t state_q;
    rxdsa_pkg::rxdsa_afc_state_t state_d;
    logic [15:0]        rate_q;
    logic [23:0]        ook_q;
    logic [23:0]        chan_q;
    logic [15:0]        tmo_q;
    logic [23:0]        carrier_q;
    logic [23:0]        carrier_d;
    logic signed [15:0] fei_q;
    logic signed [15:0] corr_q;
    logic [31:0]        prdata_q;
    logic               pready_q;
    logic               pslverr_q;
    logic               stat_tmo_q;
    logic [15:0]        phase_q;
    logic               demod_q;
    logic               data_q;
    logic               clk_q;
    logic [7:0]         decay_q;
    logic [7:0]         peak_q;
    logic [10:0]        avg_q;
    logic               ook_bit_q;
    logic               afc_run_q;
    logic [2:0]         bits_q;
    logic               rx_q;
    logic               temp_run_q;
    logic [9:0]         temp_cnt_q;
    logic [7:0]         temp_q;
    logic               level_q;
    logic               armed_q;
    logic [11:0]        tmo_cnt_q;
    logic               irq_q;
    logic [7:0]         bw_q;

    // apb: registered pready gives one access cycle, no wait states
    wire setup  = psel & ~penable;
    wire acc    = psel & penable & pready_q;
    wire wr     = acc & pwrite;
    wire a_ctrl = paddr == `RXDSA_OFF_CTRL;
    wire a_rate = paddr == `RXDSA_OFF_RATE;
    wire a_ook  = paddr == `RXDSA_OFF_OOK;
    wire a_chan = paddr == `RXDSA_OFF_CHAN;
    wire a_tmo  = paddr == `RXDSA_OFF_TMO;
    wire a_freq = paddr == `RXDSA_OFF_FREQ;
    wire a_fei  = paddr == `RXDSA_OFF_FEI;
    wire a_stat = paddr == `RXDSA_OFF_STAT;
    wire mapped = a_ctrl | a_rate | a_ook | a_chan | a_tmo | a_freq
                | a_fei | a_stat;
    wire afc_busy = state_q != rxdsa_pkg::AFC_IDLE;
    wire [31:0] stat_rd = {16'h0000, temp_q, 4'h0, stat_tmo_q,
                           afc_busy & afc_run_q, afc_busy, temp_run_q};
    wire [31:0] rd_mux =
        a_ctrl ? {23'h00_0000, ctrl_q} :
        a_rate ? {16'h0000, rate_q} :
        a_ook  ? {8'h00, ook_q} :
        a_chan ? {8'h00, chan_q} :
        a_tmo  ? {16'h0000, tmo_q} :
        a_freq ? {8'h00, carrier_q} :
        a_fei  ? {corr_q, fei_q} :
        a_stat ? stat_rd : 32'h0000_0000;

    wire launch_corr = wr & a_ctrl & pwdata[`RXDSA_BIT_CORR];
    wire launch_fei  = wr & a_ctrl & pwdata[`RXDSA_BIT_FEI];
    wire launch_temp = wr & a_ctrl & pwdata[`RXDSA_BIT_TEMP];
    wire tmo_clr     = wr & a_stat & pwdata[`RXDSA_BIT_TMO];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= setup;
            prdata_q  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
            pslverr_q <= setup & ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `RXDSA_RST_CTRL;
            rate_q <= `RXDSA_RST_RATE;
            ook_q  <= `RXDSA_RST_OOK;
            chan_q <= `RXDSA_RST_CHAN;
            tmo_q  <= `RXDSA_RST_TMO;
        end else if (wr) begin
            if (a_ctrl) ctrl_q <= pwdata[8:0];
            if (a_rate) rate_q <= pwdata[15:0];
            if (a_ook)  ook_q  <= pwdata[23:0];
            if (a_chan) chan_q <= pwdata[23:0];
            if (a_tmo)  tmo_q  <= pwdata[15:0];
        end
    end

    // bit synchronizer
    wire sync_on  = ctrl_q.packet | ~ctrl_q.sync_off;
    wire demod    = ctrl_q.ook ? ook_bit_q : fsk_bit;
    wire edge_in  = demod != demod_q;
    wire [15:0] half = {1'b0, rate_q[15:1]};
    wire wrap     = phase_q >= rate_q - 16'h0001;
    wire bit_tick = phase_q == half;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            demod_q <= 1'b0;
            phase_q <= 16'h0000;
            data_q  <= 1'b0;
            clk_q   <= 1'b0;
        end else begin
            demod_q <= demod;
            phase_q <= (edge_in | wrap) ? 16'h0000 : phase_q + 16'h0001;
            if (!sync_on) begin
                data_q <= demod_q;
                clk_q  <= 1'b0;
            end else begin
                if (bit_tick) data_q <= demod_q;
                clk_q <= phase_q >= half;
            end
        end
    end

    // ook threshold detector, rssi in 0.5 dB steps
    wire [1:0] thr_sel  = ook_q[1:0];
    wire [7:0] step     = {4'h0, ook_q[5:2]};
    wire [7:0] period   = ook_q[15:8];
    wire [7:0] floor_lv = ook_q[23:16];
    wire decay_tick     = decay_q >= period;
    wire [8:0] floor_st = {1'b0, floor_lv} + {1'b0, step};
    wire [7:0] peak_dec = ({1'b0, peak_q} <= floor_st) ? floor_lv
                        : peak_q - step;
    wire [7:0] peak_thr = (peak_q > `RXDSA_PEAK_DROP)
                        ? peak_q - `RXDSA_PEAK_DROP : 8'h00;
    wire [7:0] avg_lv   = avg_q[10:3];
    wire [7:0] thr =
        (thr_sel == rxdsa_pkg::THR_FIXED) ? floor_lv :
        (thr_sel == rxdsa_pkg::THR_AVG)   ? avg_lv : peak_thr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            decay_q   <= 8'h00;
            peak_q    <= 8'h00;
            avg_q     <= 11'h000;
            ook_bit_q <= 1'b0;
        end else begin
            decay_q <= decay_tick ? 8'h00 : decay_q + 8'h01;
            if (rssi_level > peak_q)
                peak_q <= rssi_level;
            else if (decay_tick & ~ook_bit_q & (peak_q > floor_lv))
                peak_q <= peak_dec;
            // running mean, each sample weighted one eighth, slow but cheap
            avg_q <= avg_q - {3'h0, avg_lv} + {3'h0, rssi_level};
            ook_bit_q <= rssi_level > thr;
        end
    end

    // frequency error and correction
    wire rx_on    = ctrl_q.op_mode == `RXDSA_MODE_RX;
    wire rx_rise  = rx_on & ~rx_q;
    wire auto_go  = rx_rise & ctrl_q.auto_en;
    wire man_go   = launch_corr & ~ctrl_q.auto_en;
    wire meas_end = (state_q == rxdsa_pkg::AFC_MEAS) & bit_tick
                  & (bits_q == `RXDSA_FEI_LAST);
    wire signed [15:0] ofs = ctrl_q.low_index
        ? 16'(signed'(chan_q[23:16])) <<< `RXDSA_OFS_SHIFT
        : 16'sh0000;
    wire signed [15:0] corr_new = fei_q + ofs;
    wire [23:0] corr_ext = {{8{corr_new[15]}}, corr_new};
    wire [23:0] undo_ext = {{8{corr_q[15]}}, corr_q};

    always_comb begin
        state_d = state_q;
        case (state_q)
            rxdsa_pkg::AFC_IDLE: begin
                if (auto_go | man_go)
                    state_d = (auto_go & ctrl_q.auto_clear)
                            ? rxdsa_pkg::AFC_CLEAR
                            : rxdsa_pkg::AFC_MEAS;
                else if (launch_fei)
                    state_d = rxdsa_pkg::AFC_MEAS;
            end
            rxdsa_pkg::AFC_CLEAR: state_d = rxdsa_pkg::AFC_MEAS;
            rxdsa_pkg::AFC_MEAS: begin
                if (meas_end)
                    state_d = afc_run_q ? rxdsa_pkg::AFC_APPLY
                            : rxdsa_pkg::AFC_IDLE;
            end
            default: state_d = rxdsa_pkg::AFC_IDLE;
        endcase
    end

    // hardware correction wins over a same-cycle software write
    assign carrier_d =
        (state_q == rxdsa_pkg::AFC_APPLY) ? carrier_q - corr_ext :
        (state_q == rxdsa_pkg::AFC_CLEAR) ? carrier_q + undo_ext :
        (wr & a_freq) ? pwdata[23:0] : carrier_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= rxdsa_pkg::AFC_IDLE;
            afc_run_q <= 1'b0;
            bits_q    <= 3'h0;
            rx_q      <= 1'b0;
            fei_q     <= 16'sh0000;
            corr_q    <= 16'sh0000;
            carrier_q <= `RXDSA_RST_FREQ;
        end else begin
            state_q   <= state_d;
            rx_q      <= rx_on;
            carrier_q <= carrier_d;
            if (state_q == rxdsa_pkg::AFC_IDLE) begin
                afc_run_q <= auto_go | man_go;
                bits_q    <= 3'h0;
            end else if (bit_tick && state_q == rxdsa_pkg::AFC_MEAS) begin
                bits_q <= bits_q + 3'h1;
            end
            if (meas_end) fei_q <= freq_error_in;
            if (state_q == rxdsa_pkg::AFC_CLEAR) corr_q <= 16'sh0000;
            if (state_q == rxdsa_pkg::AFC_APPLY) corr_q <= corr_new;
        end
    end

    // temperature sequencing
    wire temp_mode = (ctrl_q.op_mode == `RXDSA_MODE_STBY)
                   | (ctrl_q.op_mode == `RXDSA_MODE_FS);
    wire temp_done = temp_run_q & (temp_cnt_q == 10'(`RXDSA_TEMP_CYC));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_run_q <= 1'b0;
            temp_cnt_q <= 10'h000;
            temp_q     <= 8'h00;
        end else if (temp_done) begin
            temp_run_q <= 1'b0;
            temp_q     <= `RXDSA_TEMP_ZERO - temp_adc;
        end else if (temp_run_q) begin
            temp_cnt_q <= temp_cnt_q + 10'h001;
        end else if (launch_temp & temp_mode) begin
            temp_run_q <= 1'b1;
            temp_cnt_q <= 10'h000;
        end
    end

    // receive timeouts counted in bit periods
    wire        lvl_rise = signal_level_flag & ~level_q;
    wire [11:0] tmo_lim  = signal_level_flag
        ? {4'h0, tmo_q[15:8]} << `RXDSA_TMO_SHIFT
        : {4'h0, tmo_q[7:0]} << `RXDSA_TMO_SHIFT;
    wire tmo_hit = rx_on & armed_q & (tmo_lim != 12'h000)
                 & (tmo_cnt_q == tmo_lim);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q    <= 1'b0;
            armed_q    <= 1'b0;
            tmo_cnt_q  <= 12'h000;
            irq_q      <= 1'b0;
            stat_tmo_q <= 1'b0;
            bw_q       <= 8'h00;
        end else begin
            level_q <= signal_level_flag;
            irq_q   <= tmo_hit;
            // set wins over a same-cycle clear
            stat_tmo_q <= tmo_hit | (stat_tmo_q & ~tmo_clr);
            bw_q <= (afc_busy & afc_run_q) ? chan_q[15:8]
                  : chan_q[7:0];
            if (!rx_on) begin
                armed_q <= 1'b0;
            end else if (rx_rise | lvl_rise) begin
                armed_q   <= 1'b1;
                tmo_cnt_q <= 12'h000;
            end else if (tmo_hit) begin
                armed_q <= 1'b0;
            end else if (armed_q & bit_tick) begin
                tmo_cnt_q <= tmo_cnt_q + 12'h001;
            end
        end
    end

    assign prdata              = prdata_q;
    assign pready              = pready_q;
    assign pslverr             = pslverr_q;
    assign recovered_data      = data_q;
    assign recovered_clock_pin = clk_q;
    assign carrier_word        = carrier_q;
    assign channel_bw          = bw_q;
    assign timeout_irq         = irq_q;

    // helper: measurement length in cycles
    logic [19:0] meas_len_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) meas_len_q <= 20'h0_0000;
        else if (state_q != rxdsa_pkg::AFC_MEAS) meas_len_q <= 20'h0_0000;
        else meas_len_q <= meas_len_q + 20'h0_0001;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_meas_done;
        state_q == rxdsa_pkg::AFC_MEAS && meas_end && afc_run_q;
    endsequence
    sequence s_apply;
        state_q == rxdsa_pkg::AFC_APPLY ##1 state_q == rxdsa_pkg::AFC_IDLE;
    endsequence

    property p_peak_decay;
        rssi_level <= peak_q && decay_tick && !ook_bit_q && peak_q > floor_lv
        |=> peak_q >= $past(floor_lv) && (peak_q == $past(floor_lv)
            || peak_q == $past(peak_q) - $past(step));
    endproperty
    a_peak_decay: assert property (p_peak_decay)
        else $error("peak decay wrong");

    property p_packet_sync;
        ctrl_q.packet && bit_tick && $stable(ctrl_q) |=>
        recovered_data == $past(demod_q);
    endproperty
    a_packet_sync: assert property (p_packet_sync)
        else $error("packet mode data not synchronized");

    property p_sync_off;
        !sync_on ##1 !sync_on |-> !recovered_clock_pin;
    endproperty
    a_sync_off: assert property (p_sync_off)
        else $error("clock pin active with synchronizer off");

    property p_meas_bound;
        state_q == rxdsa_pkg::AFC_MEAS |->
        meas_len_q <= ({4'h0, rate_q} << 2) + 20'h0_0004;
    endproperty
    a_meas_bound: assert property (p_meas_bound)
        else $error("measurement exceeded four bit periods");

    property p_fei_store;
        meas_end |=> fei_q == $past(freq_error_in);
    endproperty
    a_fei_store: assert property (p_fei_store)
        else $error("error result not stored");

    property p_apply;
        s_meas_done ##1 s_apply |->
        carrier_word == $past(carrier_q) - {{8{corr_q[15]}}, corr_q};
    endproperty
    a_apply: assert property (p_apply)
        else $error("carrier not corrected");

    property p_auto_start;
        auto_go && state_q == rxdsa_pkg::AFC_IDLE |=>
        afc_run_q && state_q != rxdsa_pkg::AFC_IDLE;
    endproperty
    a_auto_start: assert property (p_auto_start)
        else $error("auto correction did not start");

    property p_clear;
        state_q == rxdsa_pkg::AFC_CLEAR |=> corr_q == 16'sh0000
        && carrier_q == $past(carrier_q) + $past(undo_ext);
    endproperty
    a_clear: assert property (p_clear)
        else $error("previous correction not cleared");

    property p_wide_bw;
        afc_busy && afc_run_q ##1 afc_busy |-> channel_bw == chan_q[15:8];
    endproperty
    a_wide_bw: assert property (p_wide_bw)
        else $error("correction bandwidth not applied");

    property p_temp_time;
        $rose(temp_run_q) |-> ##[1:999] !temp_run_q;
    endproperty
    a_temp_time: assert property (p_temp_time)
        else $error("temperature running too long");

    property p_timeout;
        tmo_hit |=> timeout_irq && stat_tmo_q;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("timeout event lost");
endmodule

/* tb/rxdsa_tx_model.sv */
`timescale 1ns/1ps
module rxdsa_tx_model #(
    parameter int BIT_CYC = 16
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic send,
    output logic      fsk_bit
);
    int cyc_q;
    int bit_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_q   <= 0;
            bit_q   <= 0;
            fsk_bit <= 1'b0;
        end else if (!send) begin
            cyc_q   <= 0;
            bit_q   <= 0;
            fsk_bit <= !fsk_bit; // no carrier: noise, never a steady level
        end else if (cyc_q == BIT_CYC - 1) begin
            cyc_q   <= 0;
            bit_q   <= bit_q + 1;
            // preamble then 0011 payload, a change every two bits
            fsk_bit <= (bit_q < 12) ? bit_q[0] : bit_q[1];
        end else begin
            cyc_q <= cyc_q + 1;
        end
    end
endmodule

/* tb/tb_rx_demod_sync_afc_control.sv */
`timescale 1ns/1ps
`include "rxdsa_map.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
    n_errors++; $display("mismatch at %0t: got %0h exp %0h", $time, \
    got, exp); end end
module tb_rx_demod_sync_afc_control;
    logic               pclk = 1'b0;
    logic               presetn;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic        [7:0]  paddr;
    logic        [31:0] pwdata;
    logic        [31:0] prdata;
    logic               pready;
    logic               pslverr;
    logic               fsk_bit;
    logic        [7:0]  rssi_level;
    logic signed [15:0] freq_error_in;
    logic        [7:0]  temp_adc;
    logic               signal_level_flag;
    logic               recovered_data;
    logic               recovered_clock_pin;
    logic        [23:0] carrier_word;
    logic        [7:0]  channel_bw;
    logic               timeout_irq;
    logic               send;
    int                 n_errors;
    int                 check_count;
    int                 cyc = 0;

    rxdsa_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fsk_bit(fsk_bit), .rssi_level(rssi_level),
        .freq_error_in(freq_error_in), .temp_adc(temp_adc),
        .signal_level_flag(signal_level_flag),
        .recovered_data(recovered_data),
        .recovered_clock_pin(recovered_clock_pin),
        .carrier_word(carrier_word), .channel_bw(channel_bw),
        .timeout_irq(timeout_irq));
    rxdsa_tx_model #(.BIT_CYC(16)) u_tx (.pclk(pclk), .presetn(presetn),
        .send(send), .fsk_bit(fsk_bit));

    always #50 pclk = !pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    task automatic print_verdict();
        if (n_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic hang();
        n_errors++;
        print_verdict();
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rdv,
                       output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) hang();
        rdv = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic        e;
        apb(1'b1, a, d, x, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0000_0000, d, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        `CHK(d, exp)
    endtask

    // poll a status bit low; returns cycles spent
    task automatic poll_low(input int b, input int bound, output int t);
        logic [31:0] d;
        int          k;
        k = 0;
        t = cyc;
        do begin
            rd(`RXDSA_OFF_STAT, d);
            k++;
        end while (d[b] !== 1'b0 && k < bound);
        if (d[b] !== 1'b0) hang();
        t = cyc - t;
    endtask

    task automatic wait_irq(input int bound, output int t);
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (timeout_irq !== 1'b1 && t < bound);
        if (timeout_irq !== 1'b1) hang();
    endtask

    task automatic t_reset();
        logic [31:0] d;
        logic        e;
        rd_chk(`RXDSA_OFF_CTRL, 32'h0000_0040);
        rd_chk(`RXDSA_OFF_RATE, 32'h0000_1a0b);
        rd_chk(`RXDSA_OFF_OOK, 32'h000c_4004);
        rd_chk(`RXDSA_OFF_CHAN, 32'h0000_8b55);
        rd_chk(`RXDSA_OFF_TMO, 32'h0000_0000);
        rd_chk(`RXDSA_OFF_FREQ, 32'h00e4_c000);
        apb(1'b0, 8'h20, 32'h0000_0000, d, e);
        `CHK(e, 1'b1)
        `CHK(d, 32'h0000_0000)
    endtask

    task automatic t_fei();
        logic [31:0] d;
        int          t;
        wr(`RXDSA_OFF_RATE, 32'h0000_0010);
        send          <= 1'b1; // preamble on air before launch
        freq_error_in <= -16'sd5;
        wr(`RXDSA_OFF_CTRL, 32'h0000_0100);
        wr(`RXDSA_OFF_CTRL, 32'h0000_0500);
        poll_low(1, 40, t);
        `CHK(t <= 4 * 16 + 8, 1'b1)
        rd(`RXDSA_OFF_FEI, d);
        `CHK(d[15:0], 16'hfffb)
    endtask

    task automatic run_corr(input logic [31:0] ctrl);
        int t;
        wr(`RXDSA_OFF_CTRL, ctrl);
        poll_low(2, 60, t);
    endtask

    task automatic t_afc();
        logic [31:0] d;
        int          t;
        wr(`RXDSA_OFF_CHAN, 32'h0002_8b55);
        freq_error_in <= 16'sd10;
        wr(`RXDSA_OFF_CTRL, 32'h0000_0110);
        wr(`RXDSA_OFF_CTRL, 32'h0000_0310);
        repeat (3) @(posedge pclk);
        `CHK(channel_bw, 8'h8b)
        poll_low(2, 60, t);
        rd(`RXDSA_OFF_FEI, d);
        `CHK(d[31:16], 16'h001a)
        `CHK(carrier_word, 24'he4_bfe6)
        `CHK(channel_bw, 8'h55)
        run_corr(32'h0000_0044);
        run_corr(32'h0000_010c); // auto on rx entry, clear first
        `CHK(carrier_word, 24'he4_bff6)
        run_corr(32'h0000_0044);
        run_corr(32'h0000_0104); // no clear: builds on last correction
        `CHK(carrier_word, 24'he4_bfec)
        rd_chk(`RXDSA_OFF_FREQ, 32'h00e4_bfec);
    endtask

    task automatic t_temp();
        logic [31:0] d;
        int          t;
        wr(`RXDSA_OFF_CTRL, 32'h0000_0040);
        temp_adc <= 8'h30;
        wr(`RXDSA_OFF_CTRL, 32'h0000_0840);
        poll_low(0, 500, t);
        `CHK(t <= 1000 + 4, 1'b1)
        `CHK(t > 8, 1'b1)
        rd(`RXDSA_OFF_STAT, d);
        `CHK(d[15:8], 8'h50)
        wr(`RXDSA_OFF_CTRL, 32'h0000_0100);
        wr(`RXDSA_OFF_CTRL, 32'h0000_0900); // refused in receive
        rd(`RXDSA_OFF_STAT, d);
        `CHK(d[0], 1'b0)
    endtask

    task automatic t_tmo();
        logic [31:0] d;
        int          t;
        wr(`RXDSA_OFF_CTRL, 32'h0000_0040);
        wr(`RXDSA_OFF_TMO, 32'h0000_0201);
        signal_level_flag <= 1'b0;
        wr(`RXDSA_OFF_CTRL, 32'h0000_0100);
        wait_irq(200, t);
        `CHK(t >= 8 * 16 - 24 && t <= 8 * 16 + 16, 1'b1)
        rd(`RXDSA_OFF_STAT, d);
        `CHK(d[3], 1'b1)
        wr(`RXDSA_OFF_STAT, 32'h0000_0008);
        rd(`RXDSA_OFF_STAT, d);
        `CHK(d[3], 1'b0)
        signal_level_flag <= 1'b1;
        wait_irq(400, t);
        `CHK(t >= 16 * 16 - 16 && t <= 16 * 16 + 16, 1'b1)
        signal_level_flag <= 1'b0;
    endtask

    // clock pin rises and data changes over a window
    task automatic count(input int n, output int r, output int c);
        logic pc;
        logic pd;
        r = 0;
        c = 0;
        pc = recovered_clock_pin;
        pd = recovered_data;
        repeat (n) begin
            @(posedge pclk);
            if (recovered_clock_pin === 1'b1 && pc === 1'b0) r++;
            if (recovered_data !== pd) c++;
            pc = recovered_clock_pin;
            pd = recovered_data;
        end
    endtask

    task automatic t_sync();
        int r;
        int c;
        wr(`RXDSA_OFF_CTRL, 32'h0000_0102);
        count(320, r, c);
        `CHK(r, 0)
        wr(`RXDSA_OFF_CTRL, 32'h0000_0103);
        count(320, r, c);
        `CHK(r >= 18 && r <= 21, 1'b1)
        wr(`RXDSA_OFF_CTRL, 32'h0000_0100);
        count(320, r, c);
        `CHK(r >= 18 && r <= 21, 1'b1)
        `CHK(c > 4, 1'b1)
        wr(`RXDSA_OFF_RATE, 32'h0000_0020);
        count(640, r, c); // transmitter stays at 16: lock lost, rate kept
        `CHK(r >= 18 && r <= 21, 1'b1)
        wr(`RXDSA_OFF_RATE, 32'h0000_0010);
        send <= 1'b0;
    endtask

    task automatic ook_chk(input logic [7:0] lvl, input logic exp);
        rssi_level <= lvl;
        repeat (4) @(posedge pclk);
        `CHK(recovered_data, exp)
    endtask

    task automatic t_ook();
        wr(`RXDSA_OFF_CTRL, 32'h0000_0122);
        wr(`RXDSA_OFF_OOK, 32'h0040_0001);
        ook_chk(8'h50, 1'b1);
        ook_chk(8'h30, 1'b0);
        wr(`RXDSA_OFF_OOK, 32'h0040_ff00); // peak, no decay
        ook_chk(8'h80, 1'b1);
        ook_chk(8'h78, 1'b1);
        ook_chk(8'h70, 1'b0);
        wr(`RXDSA_OFF_OOK, 32'h0040_0010); // fast decay
        ook_chk(8'h00, 1'b0);
        repeat (100) @(posedge pclk);
        ook_chk(8'h50, 1'b1);
        ook_chk(8'h30, 1'b0);
        wr(`RXDSA_OFF_OOK, 32'h0040_0002); // average threshold
        repeat (100) @(posedge pclk);
        ook_chk(8'h50, 1'b1);
        repeat (100) @(posedge pclk);
        ook_chk(8'h50, 1'b0);
    endtask

    initial begin
        presetn           = 1'b0;
        psel              = 1'b0;
        penable           = 1'b0;
        pwrite            = 1'b0;
        paddr             = 8'h00;
        pwdata            = 32'h0000_0000;
        rssi_level        = 8'h00;
        freq_error_in     = 16'sh0000;
        temp_adc          = 8'h00;
        signal_level_flag = 1'b0;
        send              = 1'b0;
        n_errors          = 0;
        check_count       = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_fei();
        t_afc();
        t_temp();
        t_tmo();
        send <= 1'b1;
        t_sync();
        t_ook();
        print_verdict();
    end
endmodule
